// ---- hw/uaf_top.sv ----
// FIFO control and DMA-ready signalling with an AHB-Lite register slave
`timescale 1ns/1ps
module uaf_top (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic tx_out_valid,
    output logic [7:0] tx_out_data,
    input wire logic tx_out_ready,
    input wire logic rx_in_valid,
    input wire logic [7:0] rx_in_data,
    output logic rx_in_ready,
    output logic tx_slot_ready_n,
    output logic rx_char_ready_n,
    output logic tx_int,
    output logic rx_int
);
    // Control fields
    logic fifo_enable;
    logic dma_mode_select;
    logic deep_fifo_select;
    logic [1:0] rx_threshold_field;
    // Bus pipeline
    logic ap_take;
    logic dp_write;
    logic [7:0] dp_addr;
    logic wr_ctrl;
    logic wr_tx;
    logic rd_rx;
    // FIFO wiring
    logic [6:0] cap;
    logic [6:0] trigger;
    logic tx_flush;
    logic rx_flush;
    logic refit;
    logic [7:0] tx_head;
    logic [6:0] tx_cnt;
    logic tx_full;
    logic tx_pop;
    logic skid_tx_ready;
    logic [7:0] rx_head;
    logic [6:0] rx_cnt;
    logic rx_full;
    logic rx_skid_valid;
    logic [7:0] rx_skid_data;
    logic rx_push;
    logic mode1;
    logic next_tx_ready_n;
    logic next_rx_ready_n;
    logic [31:0] next_rdata;

    // Trigger level lookup from the threshold field
    function automatic logic [6:0] trig_level(input logic deep, input logic [1:0] sel);
        logic [6:0] lvl;
        lvl = uaf_pkg::TRIG_S0;
        case (sel)
            2'h0: lvl = deep ? uaf_pkg::TRIG_D0 : uaf_pkg::TRIG_S0; // RL9
            2'h1: lvl = deep ? uaf_pkg::TRIG_D1 : uaf_pkg::TRIG_S1; // RL9
            2'h2: lvl = deep ? uaf_pkg::TRIG_D2 : uaf_pkg::TRIG_S2; // RL9
            2'h3: lvl = deep ? uaf_pkg::TRIG_D3 : uaf_pkg::TRIG_S3; // RL9
            default: lvl = uaf_pkg::TRIG_S0;
        endcase
        return lvl;
    endfunction

    // Address phase accepted when selected, non-idle and bus ready
    assign ap_take = hsel && htrans[1] && hready;
    assign wr_ctrl = dp_write && (dp_addr == uaf_pkg::OFS_FIFO_CONTROL);
    assign wr_tx = dp_write && (dp_addr == uaf_pkg::OFS_TX_DATA);
    // Unmapped reads that alias the receive offset must not pop
    assign rd_rx = ap_take && !hwrite && (haddr[31:8] == 24'h000000) && (haddr[7:0] == uaf_pkg::OFS_RX_DATA)
                   && (rx_cnt != 7'h00);

    // Data phase tracking; every transfer is zero wait
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else begin
            dp_write <= ap_take && hwrite && (haddr[31:8] == 24'h000000);
            dp_addr <= haddr[7:0];
        end
    end

    // Control register; flush bits and bit 4 are never stored
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            fifo_enable <= uaf_pkg::FIFO_CONTROL_RESET[uaf_pkg::FC_ENABLE];
            dma_mode_select <= uaf_pkg::FIFO_CONTROL_RESET[uaf_pkg::FC_DMA_MODE];
            deep_fifo_select <= uaf_pkg::FIFO_CONTROL_RESET[uaf_pkg::FC_DEEP];
            rx_threshold_field <= uaf_pkg::FIFO_CONTROL_RESET[uaf_pkg::FC_THR_HI:uaf_pkg::FC_THR_LO];
        end else if (wr_ctrl) begin
            fifo_enable <= hwdata[uaf_pkg::FC_ENABLE]; // RL10
            dma_mode_select <= hwdata[uaf_pkg::FC_DMA_MODE]; // RL1
            deep_fifo_select <= hwdata[uaf_pkg::FC_DEEP]; // RL8
            rx_threshold_field <= hwdata[uaf_pkg::FC_THR_HI:uaf_pkg::FC_THR_LO]; // RL7 RL13
        end
    end

    // Capacity: one holding slot when disabled, else 16 or 64
    always_comb begin
        if (!fifo_enable) begin
            cap = uaf_pkg::DEPTH_OFF; // RL10
        end else if (deep_fifo_select) begin
            cap = uaf_pkg::DEPTH_DEEP; // RL8
        end else begin
            cap = uaf_pkg::DEPTH_SHALLOW; // RL8
        end
    end

    assign trigger = trig_level(deep_fifo_select, rx_threshold_field); // RL7
    assign mode1 = dma_mode_select && fifo_enable; // RL1

    // Flush pulses last one cycle; a capacity change also empties both FIFOs
    assign refit = wr_ctrl && ((hwdata[uaf_pkg::FC_ENABLE] != fifo_enable)
                               || (hwdata[uaf_pkg::FC_DEEP] != deep_fifo_select));
    assign tx_flush = (wr_ctrl && hwdata[uaf_pkg::FC_TX_FLUSH]) || refit; // RL11
    assign rx_flush = (wr_ctrl && hwdata[uaf_pkg::FC_RX_FLUSH]) || refit; // RL11

    // Transmit FIFO, fed by bus writes
    uaf_fifo u_tx_fifo (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .flush(tx_flush),
        .cap(cap),
        .push(wr_tx),
        .push_data(hwdata[7:0]),
        .pop(tx_pop),
        .pop_data(tx_head),
        .count(tx_cnt),
        .full(tx_full)
    );

    // Head moves to the output buffer, which a flush leaves alone
    assign tx_pop = (tx_cnt != 7'h00) && skid_tx_ready && !tx_flush; // RL11

    uaf_skid u_tx_skid (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_valid(tx_pop),
        .in_data(tx_head),
        .in_ready(skid_tx_ready),
        .out_valid(tx_out_valid),
        .out_data(tx_out_data),
        .out_ready(tx_out_ready)
    );

    // Receive characters land in a buffer that stalls the source when full
    uaf_skid u_rx_skid (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_valid(rx_in_valid),
        .in_data(rx_in_data),
        .in_ready(rx_in_ready),
        .out_valid(rx_skid_valid),
        .out_data(rx_skid_data),
        .out_ready(rx_push)
    );

    // Keep filling past the trigger until full
    assign rx_push = rx_skid_valid && !rx_full && !rx_flush; // RL5 RL7

    uaf_fifo u_rx_fifo (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .flush(rx_flush),
        .cap(cap),
        .push(rx_push),
        .push_data(rx_skid_data),
        .pop(rd_rx),
        .pop_data(rx_head),
        .count(rx_cnt),
        .full(rx_full)
    );

    // Ready outputs for the next edge
    always_comb begin
        if (mode1) begin
            if (tx_full) begin
                next_tx_ready_n = 1'b1; // RL12
            end else if (tx_cnt == 7'h00) begin
                next_tx_ready_n = 1'b0; // RL12
            end else begin
                next_tx_ready_n = tx_slot_ready_n;
            end
            if (rx_cnt == 7'h00) begin
                next_rx_ready_n = 1'b1;
            end else if (rx_cnt >= trigger) begin
                next_rx_ready_n = 1'b0; // RL6
            end else begin
                next_rx_ready_n = rx_char_ready_n;
            end
        end else begin
            next_tx_ready_n = (tx_cnt != 7'h00); // RL2
            next_rx_ready_n = (rx_cnt == 7'h00); // RL3
        end
    end

    // Registered ready and interrupt conditions
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            tx_slot_ready_n <= uaf_pkg::TX_READY_N_RESET;
            rx_char_ready_n <= uaf_pkg::RX_READY_N_RESET;
            tx_int <= 1'b0;
            rx_int <= 1'b0;
        end else begin
            tx_slot_ready_n <= next_tx_ready_n;
            rx_char_ready_n <= next_rx_ready_n;
            tx_int <= mode1 ? (tx_cnt < trigger) : (tx_cnt == 7'h00); // RL4
            rx_int <= fifo_enable ? (rx_cnt >= trigger) : (rx_cnt != 7'h00); // RL5 RL7
        end
    end

    // Read data chosen in the address phase
    always_comb begin
        next_rdata = 32'h00000000;
        case (haddr[7:0])
            uaf_pkg::OFS_FIFO_CONTROL: begin
                next_rdata[uaf_pkg::FC_ENABLE] = fifo_enable;
                next_rdata[uaf_pkg::FC_DMA_MODE] = dma_mode_select;
                next_rdata[uaf_pkg::FC_DEEP] = deep_fifo_select;
                next_rdata[uaf_pkg::FC_THR_HI:uaf_pkg::FC_THR_LO] = rx_threshold_field;
            end
            uaf_pkg::OFS_RX_DATA: begin
                next_rdata[7:0] = (rx_cnt != 7'h00) ? rx_head : 8'h00;
            end
            uaf_pkg::OFS_STATUS: begin
                next_rdata[uaf_pkg::ST_TX_CNT_LO +: 7] = tx_cnt;
                next_rdata[uaf_pkg::ST_RX_CNT_LO +: 7] = rx_cnt;
                next_rdata[uaf_pkg::ST_TX_READY_N] = tx_slot_ready_n;
                next_rdata[uaf_pkg::ST_RX_READY_N] = rx_char_ready_n;
                next_rdata[uaf_pkg::ST_TX_INT] = tx_int;
                next_rdata[uaf_pkg::ST_RX_INT] = rx_int;
            end
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Bus answer registers; reads with hsize 7 return zero, all other accesses are whole words
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= uaf_pkg::HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= uaf_pkg::HRESP_OKAY;
            if (ap_take && !hwrite && (haddr[31:8] == 24'h000000) && (hsize != 3'h7)) begin
                hrdata <= next_rdata;
            end else if (ap_take) begin
                hrdata <= 32'h00000000;
            end
        end
    end
endmodule

// ---- hw/uaf_pkg.sv ----
// Constants for the UART FIFO control and DMA-ready block
// Notes on behaviour
// RL1 - Control bit 3 selects DMA mode 1
// RL2 - Mode 0: transmit ready low while transmit empty
// RL3 - Mode 0: receive ready low while characters held
// RL4 - Mode 1: transmit interrupt below trigger level
// RL5 - Mode 1: receive interrupt at trigger, keep filling
// RL6 - Mode 1: receive ready low at or above trigger
// RL7 - Bits 7:6 pick receive trigger level
// RL8 - Control bit 5 selects 64-byte depth
// RL9 - Levels 1/4/8/14 or 1/16/32/56 bytes
// RL10 - Control bit 0 enables both FIFOs
// RL11 - Bits 2/1 flush transmit/receive FIFO, self-clear
// RL12 - Mode 1: transmit ready high full, low empty
// RL13 - Control bit 4 reserved, no effect
package uaf_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_FIFO_CONTROL = 8'h00;
    localparam logic [7:0] OFS_TX_DATA = 8'h04;
    localparam logic [7:0] OFS_RX_DATA = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    // Control field positions
    localparam int FC_ENABLE = 0;
    localparam int FC_RX_FLUSH = 1;
    localparam int FC_TX_FLUSH = 2;
    localparam int FC_DMA_MODE = 3;
    localparam int FC_DEEP = 5;
    localparam int FC_THR_LO = 6;
    localparam int FC_THR_HI = 7;
    // Status field positions
    localparam int ST_TX_CNT_LO = 0;
    localparam int ST_RX_CNT_LO = 8;
    localparam int ST_TX_READY_N = 16;
    localparam int ST_RX_READY_N = 17;
    localparam int ST_TX_INT = 18;
    localparam int ST_RX_INT = 19;
    // Reset values
    localparam logic [7:0] FIFO_CONTROL_RESET = 8'h00;
    localparam logic TX_READY_N_RESET = 1'b0;
    localparam logic RX_READY_N_RESET = 1'b1;
    // Data and depth figures
    localparam int DATA_W = 8;
    localparam int CNT_W = 7;
    localparam int PTR_W = 6;
    localparam int STORE_DEPTH = 64;
    localparam logic [6:0] DEPTH_OFF = 7'h01;
    localparam logic [6:0] DEPTH_SHALLOW = 7'h10;
    localparam logic [6:0] DEPTH_DEEP = 7'h40;
    // Receive trigger levels, shallow then deep
    localparam logic [6:0] TRIG_S0 = 7'h01;
    localparam logic [6:0] TRIG_S1 = 7'h04;
    localparam logic [6:0] TRIG_S2 = 7'h08;
    localparam logic [6:0] TRIG_S3 = 7'h0E;
    localparam logic [6:0] TRIG_D0 = 7'h01;
    localparam logic [6:0] TRIG_D1 = 7'h10;
    localparam logic [6:0] TRIG_D2 = 7'h20;
    localparam logic [6:0] TRIG_D3 = 7'h38;
    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
endpackage

// ---- hw/uaf_fifo.sv ----
// Character FIFO with run-time capacity and flush
`timescale 1ns/1ps
module uaf_fifo (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic flush,
    input wire logic [6:0] cap,
    input wire logic push,
    input wire logic [7:0] push_data,
    input wire logic pop,
    output logic [7:0] pop_data,
    output logic [6:0] count,
    output logic full
);
    logic [7:0] mem [0:uaf_pkg::STORE_DEPTH-1];
    logic [5:0] wr_ptr;
    logic [5:0] rd_ptr;
    logic do_push;
    logic do_pop;

    // Push only with room, pop only with data
    assign do_push = push && !full;
    assign do_pop = pop && (count != 7'h00);
    assign full = (count >= cap);
    assign pop_data = mem[rd_ptr];

    // Pointers and count; flush wins over both sides
    always_ff @(posedge sys_clk) begin
        if (!nrst || flush) begin
            wr_ptr <= 6'h00;
            rd_ptr <= 6'h00;
            count <= 7'h00;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 6'h01;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 6'h01;
            end
            count <= count + {6'h00, do_push} - {6'h00, do_pop};
        end
    end

    // Storage written at the write pointer
    always_ff @(posedge sys_clk) begin
        if (do_push && !flush) begin
            mem[wr_ptr] <= push_data;
        end
    end
endmodule

// ---- hw/uaf_skid.sv ----
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module uaf_skid (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [7:0] out_data,
    input wire logic out_ready
);
    logic [7:0] spare;
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Occupancy after this edge
    always_comb begin
        next_cnt = cnt;
        if (push && !pop) begin
            next_cnt = cnt + 2'h1;
        end else if (pop && !push) begin
            next_cnt = cnt - 2'h1;
        end
    end

    // Occupancy and handshake flags
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cnt <= 2'h0;
            out_valid <= 1'b0;
            in_ready <= 1'b0;
        end else begin
            cnt <= next_cnt;
            out_valid <= (next_cnt != 2'h0);
            in_ready <= (next_cnt != 2'h2); // Stall source when both entries hold
        end
    end

    // Head and spare entries
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            out_data <= 8'h00;
            spare <= 8'h00;
        end else if (pop) begin
            if (cnt == 2'h2) begin
                out_data <= spare;
                spare <= in_data;
            end else begin
                out_data <= in_data;
            end
        end else if (push) begin
            if (cnt == 2'h0) begin
                out_data <= in_data;
            end else begin
                spare <= in_data;
            end
        end
    end
endmodule

// ---- tb/uaf_chk.sv ----
// Port checker for the FIFO control and DMA-ready block
`timescale 1ns/1ps
module uaf_chk (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic tx_out_valid,
    input wire logic [7:0] tx_out_data,
    input wire logic tx_out_ready,
    input wire logic rx_in_valid,
    input wire logic rx_in_ready,
    input wire logic tx_slot_ready_n,
    input wire logic rx_char_ready_n,
    input wire logic tx_int,
    input wire logic rx_int
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Accepted address phase
    wire acc = hsel && htrans[1] && hready;
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("bad response");
    property p_nowait; hreadyout == 1'b1; endproperty
    a_nowait: assert property (p_nowait) else $error("wait state");
    property p_rst;
        disable iff (1'b0) !nrst |=> !tx_out_valid && rx_char_ready_n && !tx_slot_ready_n && !rx_int && !tx_int;
    endproperty
    a_rst: assert property (p_rst) else $error("reset outputs wrong");
    property p_rdhold; !$past(acc) |-> $stable(hrdata); endproperty
    a_rdhold: assert property (p_rdhold) else $error("read data moved");
    property p_unmap; acc && !hwrite && haddr[31:8] != 24'h0 |=> hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_txhold; tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out_data); endproperty
    a_txhold: assert property (p_txhold) else $error("tx char dropped");
    property p_rxint; rx_int |-> !rx_char_ready_n; endproperty
    a_rxint: assert property (p_rxint) else $error("rx int without ready");
    property p_rxfall; $fell(rx_in_ready) |-> $past(rx_in_valid); endproperty
    a_rxfall: assert property (p_rxfall) else $error("rx refused idle");
    property p_rxempty; $rose(rx_char_ready_n) |-> $past(acc, 2) || $past(acc, 3) || $past(acc, 4); endproperty
    a_rxempty: assert property (p_rxempty) else $error("rx ready lost");
    c_rxint: cover property (rx_int);
    c_stall: cover property (tx_out_valid && !tx_out_ready);
    c_rxfull: cover property (rx_in_valid && !rx_in_ready);
    c_txfull: cover property ($rose(tx_slot_ready_n));
endmodule
bind uaf_top uaf_chk i_chk (.sys_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hrdata,
    .hresp, .tx_out_valid, .tx_out_data, .tx_out_ready, .rx_in_valid, .rx_in_ready, .tx_slot_ready_n,
    .rx_char_ready_n, .tx_int, .rx_int);

// ---- tb/uaf_eng_model.sv ----
// Model of the serial engines beyond the character streams
`timescale 1ns/1ps
module uaf_eng_model (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic stall,
    input wire logic tx_out_valid,
    output logic tx_out_ready,
    output logic rx_in_valid,
    output logic [7:0] rx_in_data,
    input wire logic rx_in_ready
);
    logic [1:0] ph = 2'h0;
    initial begin
        tx_out_ready = 1'b0;
        rx_in_valid = 1'b0;
        rx_in_data = 8'hA5;
    end
    // Takes three characters in four unless stalled
    always @(posedge sys_clk) begin
        ph <= nrst ? ph + 2'h1 : 2'h0;
        tx_out_ready <= nrst && !stall && ph != 2'h3;
    end
    // Offers one character and holds it until taken
    task automatic send(input logic [7:0] b);
        rx_in_valid <= 1'b1;
        rx_in_data <= b;
        @(posedge sys_clk);
        while (rx_in_ready !== 1'b1) @(posedge sys_clk);
    endtask
    // Releases the line with data scrambled
    task automatic idle;
        rx_in_valid <= 1'b0;
        rx_in_data <= ~rx_in_data;
    endtask
endmodule

// ---- tb/uaf_top_tb.sv ----
// Self-checking bench for the FIFO control and DMA-ready block
`timescale 1ns/1ps
module uaf_top_tb;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic stall = 1'b0;
    logic rd_ph = 1'b0;
    logic hreadyout, hresp, tx_out_valid, tx_out_ready, rx_in_valid, rx_in_ready;
    logic tx_slot_ready_n, rx_char_ready_n, tx_int, rx_int;
    logic [31:0] hrdata;
    logic [7:0] tx_out_data, rx_in_data, b;
    logic [31:0] seed = 32'hEEF09115;
    logic [31:0] rdq[$];
    logic [7:0] txq[$];
    int stab[4] = '{1, 4, 8, 14};
    int dtab[4] = '{1, 16, 32, 56};
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    int trg;
    uaf_top i_dut (.sys_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp, .tx_out_valid, .tx_out_data, .tx_out_ready, .rx_in_valid, .rx_in_data,
        .rx_in_ready, .tx_slot_ready_n, .rx_char_ready_n, .tx_int, .rx_int);
    uaf_eng_model i_eng (.sys_clk, .nrst, .stall, .tx_out_valid, .tx_out_ready, .rx_in_valid, .rx_in_data,
        .rx_in_ready);
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    function automatic logic [7:0] nb();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // One single-word transfer, address phase then data phase
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph <= !w;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rd_ph <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        rdq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Watches read data, transmit characters and the cycle limit
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (rd_ph && hreadyout === 1'b1) check(hrdata, rdq.pop_front(), "hrdata");
        if (nrst && tx_out_valid === 1'b1 && tx_out_ready === 1'b1)
            check({24'h0, tx_out_data}, {24'h0, txq.pop_front()}, "tx byte");
        // Cycle limit reached: count it and close the run
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        rd(32'h0, 32'h0);
        rd(32'hC, 32'h00060000);
        rd(32'h100, 32'h0);
        rd(32'h10, 32'h0);
        bus(1'b1, 32'h0, 32'hFF);
        rd(32'h0, 32'hE9);
        // Every threshold code at both depths in mode 1
        for (int k = 0; k < 8; k++) begin
            trg = k[2] ? dtab[k[1:0]] : stab[k[1:0]];
            bus(1'b1, 32'h0, {24'h0, k[1:0], k[2], 5'h0F});
            for (int i = 1; i < trg; i++) i_eng.send(nb());
            i_eng.idle();
            tick(6);
            rd(32'hC, 32'((trg - 1) << 8) | 32'h00060000);
            i_eng.send(nb());
            i_eng.idle();
            tick(6);
            rd(32'hC, 32'(trg << 8) | 32'h000C0000);
        end
        // Stalled transmit in mode 0 then filled to full in mode 1
        for (int m = 0; m < 2; m++) begin
            stall <= 1'b1;
            bus(1'b1, 32'h0, m ? 32'h0F : 32'h07);
            for (int i = 0; i < (m ? 19 : 3); i++) begin
                b = nb();
                if (i < 18) txq.push_back(b);
                bus(1'b1, 32'h4, {24'h0, b});
            end
            tick(4);
            rd(32'hC, m ? 32'h00030010 : 32'h00030001);
            stall <= 1'b0;
            tick(60);
            #1;
            check({31'h0, tx_slot_ready_n}, 32'h0, "tx_slot_ready_n");
            check({31'h0, tx_int}, 32'h1, "tx_int");
        end
        // FIFOs off: holding register plus buffer refuse a fourth
        bus(1'b1, 32'h0, 32'h06);
        for (int i = 0; i < 3; i++) begin
            b = nb();
            rdq.push_back({24'h0, b});
            i_eng.send(b);
        end
        i_eng.idle();
        tick(4);
        #1;
        check({31'h0, rx_in_ready}, 32'h0, "rx_in_ready");
        check({31'h0, rx_char_ready_n}, 32'h0, "rx_char_ready_n");
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, 32'h8, 32'h0);
            tick(4);
        end
        #1;
        check({31'h0, rx_char_ready_n}, 32'h1, "rx_char_ready_n");
        end_sim();
    end
endmodule
